//--- verilog/rtk_timekeeper.sv
// Real-time clock with keyed time counters, calibration, midnight flag and interval alarm.
`timescale 1ns/1ps
module rtk_timekeeper
  import rtk_pkg::*;
(
  // System clock and resets
  input  wire logic       CLK,
  input  wire logic       RST,
  input  wire logic       POR,
  // Crystal oscillator
  input  wire logic       XTAL_CLK,
  // Special function register bus
  input  wire logic [7:0] SFR_ADDR,
  input  wire logic [7:0] SFR_WDATA,
  input  wire logic       SFR_WR,
  input  wire logic       SFR_RD,
  output logic      [7:0] SFR_RDATA,
  // Status to the core and power controller
  output logic            RTC_IRQ,
  output logic            DEEP_SLEEP_OK
);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  logic [2:0] xtal_sync_r;
  logic       xtal_rise;
  logic [9:0] prescale_r;
  logic [9:0] period_r;
  logic [9:0] period_nxt;
  logic       frac_tick;
  logic       sec_tick;
  logic       min_tick;
  logic       hour_tick;
  logic       day_tick;
  logic [7:0] fraction_r;
  logic [7:0] second_r;
  logic [7:0] minute_r;
  logic [7:0] hour_r;
  logic [7:0] interval_r;
  logic [7:0] nomcomp_r;
  logic [7:0] tempcomp_r;
  logic [7:0] key_r;
  logic [7:0] intpin_r;
  logic       midnight_r;
  logic       hourfmt_r;
  logic [1:0] tbase_r;
  logic       oneshot_r;
  logic       alarm_r;
  logic       iton_r;
  logic       resv_r;
  logic       unlocked;
  logic       wr_config;
  logic       sys_rst;
  logic [7:0] config_val;
  logic [7:0] rdata_nxt;
  logic [7:0] rdata_r;
  logic       irq_r;
  logic       sleep_ok_r;

  rtk_ival_if ival ();

  // ---------------------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------------------

  // Write strobe for one protected or plain register address.
  function automatic logic wr_hit(input logic [7:0] addr, input logic [7:0] target, input logic wr);
    wr_hit = wr && (addr == target);
  endfunction

  // Last hour value before the wrap, for the selected hour format.
  function automatic logic [7:0] hour_limit(input logic fmt24);
    hour_limit = fmt24 ? RTK_HOUR24_MAX : RTK_HOUR256_MAX;
  endfunction

  // ---------------------------------------------------------------------------
  // Crystal edge detection
  // ---------------------------------------------------------------------------

  // Two stages resynchronise the crystal, the third stage feeds the edge detector.
  always_ff @(posedge CLK) begin
    if (POR) begin
      xtal_sync_r <= 3'h0;
    end else begin
      xtal_sync_r <= {xtal_sync_r[1:0], XTAL_CLK};
    end
  end

  assign xtal_rise = xtal_sync_r[1] && !xtal_sync_r[2];

  // ---------------------------------------------------------------------------
  // Calibrated prescaler
  // ---------------------------------------------------------------------------

  // Nominal period minus the signed sum of both compensation trims.
  assign period_nxt = RTK_XTAL_PER_TICK
                      - {{2{nomcomp_r[7]}}, nomcomp_r}
                      - {{2{tempcomp_r[7]}}, tempcomp_r};

  // Trimmed period is loaded once per second so the correction applies per second.
  always_ff @(posedge CLK) begin
    if (POR) begin
      period_r <= RTK_XTAL_PER_TICK;
    end else if (sec_tick || period_r == 10'h000) begin
      period_r <= period_nxt;
    end
  end

  // Crystal edges are counted; sleep modes never gate this path.
  always_ff @(posedge CLK) begin
    if (POR) begin
      prescale_r <= 10'h000;
    end else if (xtal_rise) begin
      if (prescale_r + 10'h001 >= period_r) begin
        prescale_r <= 10'h000;
      end else begin
        prescale_r <= prescale_r + 10'h001;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Carry chain
  // ---------------------------------------------------------------------------

  // Each carry fires in the cycle the lower counter wraps.
  assign frac_tick = xtal_rise && (prescale_r + 10'h001 >= period_r);
  assign sec_tick  = frac_tick && (fraction_r == RTK_FRACTION_MAX);
  assign min_tick  = sec_tick && (second_r == RTK_SEC_MAX);
  assign hour_tick = min_tick && (minute_r == RTK_MIN_MAX);
  assign day_tick  = hour_tick && (hour_r == hour_limit(hourfmt_r));

  // ---------------------------------------------------------------------------
  // Register bus decode
  // ---------------------------------------------------------------------------

  // Key must hold the unlock value for protected writes to land.
  assign unlocked  = (key_r == RTK_UNLOCK_KEY);
  assign wr_config = wr_hit(SFR_ADDR, RTK_ADDR_CONFIG, SFR_WR);
  assign sys_rst   = RST || POR;

  // Key register is cleared by any reset; software writes it freely.
  always_ff @(posedge CLK) begin
    if (sys_rst) begin
      key_r <= RTK_RST_REG;
    end else if (wr_hit(SFR_ADDR, RTK_ADDR_KEY, SFR_WR)) begin
      key_r <= SFR_WDATA;
    end
  end

  // Interrupt pin configuration is only stored, and only while unlocked.
  always_ff @(posedge CLK) begin
    if (sys_rst) begin
      intpin_r <= RTK_RST_REG;
    end else if (wr_hit(SFR_ADDR, RTK_ADDR_INTPIN, SFR_WR) && unlocked) begin
      intpin_r <= SFR_WDATA;
    end
  end

  // ---------------------------------------------------------------------------
  // Time counters
  // ---------------------------------------------------------------------------

  // Fraction counter, cleared only by power-on; an unlocked write beats the count.
  always_ff @(posedge CLK) begin
    if (POR) begin
      fraction_r <= RTK_RST_REG;
    end else if (wr_hit(SFR_ADDR, RTK_ADDR_FRACTION, SFR_WR) && unlocked) begin
      fraction_r <= SFR_WDATA;
    end else if (sec_tick) begin
      fraction_r <= RTK_RST_REG;
    end else if (frac_tick) begin
      fraction_r <= fraction_r + 8'h01;
    end
  end

  // Seconds counter.
  always_ff @(posedge CLK) begin
    if (POR) begin
      second_r <= RTK_RST_REG;
    end else if (wr_hit(SFR_ADDR, RTK_ADDR_SECOND, SFR_WR) && unlocked) begin
      second_r <= SFR_WDATA;
    end else if (min_tick) begin
      second_r <= RTK_RST_REG;
    end else if (sec_tick) begin
      second_r <= second_r + 8'h01;
    end
  end

  // Minutes counter.
  always_ff @(posedge CLK) begin
    if (POR) begin
      minute_r <= RTK_RST_REG;
    end else if (wr_hit(SFR_ADDR, RTK_ADDR_MINUTE, SFR_WR) && unlocked) begin
      minute_r <= SFR_WDATA;
    end else if (hour_tick) begin
      minute_r <= RTK_RST_REG;
    end else if (min_tick) begin
      minute_r <= minute_r + 8'h01;
    end
  end

  // Hours counter with selectable wrap point.
  always_ff @(posedge CLK) begin
    if (POR) begin
      hour_r <= RTK_RST_REG;
    end else if (wr_hit(SFR_ADDR, RTK_ADDR_HOUR, SFR_WR) && unlocked) begin
      hour_r <= SFR_WDATA;
    end else if (day_tick) begin
      hour_r <= RTK_RST_REG;
    end else if (hour_tick) begin
      hour_r <= hour_r + 8'h01;
    end
  end

  // ---------------------------------------------------------------------------
  // Compensation and interval registers
  // ---------------------------------------------------------------------------

  // Compensation trims survive system resets and clear at power-on.
  always_ff @(posedge CLK) begin
    if (POR) begin
      nomcomp_r  <= RTK_RST_REG;
      tempcomp_r <= RTK_RST_REG;
    end else begin
      if (wr_hit(SFR_ADDR, RTK_ADDR_NOMCOMP, SFR_WR)) begin
        nomcomp_r <= SFR_WDATA;
      end
      if (wr_hit(SFR_ADDR, RTK_ADDR_TEMPCOMP, SFR_WR)) begin
        tempcomp_r <= SFR_WDATA;
      end
    end
  end

  // Interval limit register.
  always_ff @(posedge CLK) begin
    if (sys_rst) begin
      interval_r <= RTK_RST_REG;
    end else if (wr_hit(SFR_ADDR, RTK_ADDR_INTERVAL, SFR_WR)) begin
      interval_r <= SFR_WDATA;
    end
  end

  // ---------------------------------------------------------------------------
  // Configuration register
  // ---------------------------------------------------------------------------

  // Hour format is kept through system resets.
  always_ff @(posedge CLK) begin
    if (POR) begin
      hourfmt_r <= 1'b0;
    end else if (wr_config) begin
      hourfmt_r <= SFR_WDATA[RTK_BIT_HOURFMT];
    end
  end

  // Plain control fields, returned to defaults by any reset.
  always_ff @(posedge CLK) begin
    if (sys_rst) begin
      tbase_r   <= RTK_TB_FRACTION;
      oneshot_r <= 1'b0;
      iton_r    <= 1'b0;
      resv_r    <= RTK_RST_RESV;
    end else if (wr_config) begin
      tbase_r   <= SFR_WDATA[RTK_BIT_TBASE_HI:RTK_BIT_TBASE_LO];
      oneshot_r <= SFR_WDATA[RTK_BIT_ONESHOT];
      iton_r    <= SFR_WDATA[RTK_BIT_ITON];
      resv_r    <= SFR_WDATA[RTK_BIT_RESV];
    end
  end

  // Midnight flag: a rollover in the same cycle as a clearing write wins.
  always_ff @(posedge CLK) begin
    if (sys_rst) begin
      midnight_r <= 1'b0;
    end else if (day_tick) begin
      midnight_r <= 1'b1;
    end else if (wr_config && !SFR_WDATA[RTK_BIT_MIDNIGHT]) begin
      midnight_r <= 1'b0;
    end
  end

  // Alarm flag: writing one has no effect, and a hit beats a clearing write.
  always_ff @(posedge CLK) begin
    if (sys_rst) begin
      alarm_r <= 1'b0;
    end else if (ival.hit) begin
      alarm_r <= 1'b1;
    end else if (wr_config && !SFR_WDATA[RTK_BIT_ALARM]) begin
      alarm_r <= 1'b0;
    end
  end

  // Packed view of the configuration register.
  assign config_val = {midnight_r, hourfmt_r, tbase_r, oneshot_r, alarm_r, iton_r, resv_r};

  // ---------------------------------------------------------------------------
  // Interval timer
  // ---------------------------------------------------------------------------

  // Tick source picked from the carry chain by the time base field.
  always_comb begin
    case (tbase_r)
      RTK_TB_FRACTION: ival.tick = frac_tick;
      RTK_TB_SECOND:   ival.tick = sec_tick;
      RTK_TB_MINUTE:   ival.tick = min_tick;
      RTK_TB_HOUR:     ival.tick = hour_tick;
      default:         ival.tick = 1'b0;
    endcase
  end

  assign ival.enable  = iton_r && !sys_rst;
  assign ival.oneshot = oneshot_r;
  assign ival.limit   = interval_r;

  // Interval counter.
  rtk_ival u_ival (
    .clk (CLK),
    .rst (sys_rst),
    .bus (ival.tmr)
  );

  // ---------------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------------

  // Byte-wide read multiplexer; unmapped addresses read as zero.
  always_comb begin
    case (SFR_ADDR)
      RTK_ADDR_CONFIG:   rdata_nxt = config_val;
      RTK_ADDR_FRACTION: rdata_nxt = fraction_r;
      RTK_ADDR_SECOND:   rdata_nxt = second_r;
      RTK_ADDR_MINUTE:   rdata_nxt = minute_r;
      RTK_ADDR_HOUR:     rdata_nxt = hour_r;
      RTK_ADDR_INTERVAL: rdata_nxt = interval_r;
      RTK_ADDR_KEY:      rdata_nxt = key_r;
      RTK_ADDR_NOMCOMP:  rdata_nxt = nomcomp_r;
      RTK_ADDR_TEMPCOMP: rdata_nxt = tempcomp_r;
      RTK_ADDR_INTPIN:   rdata_nxt = intpin_r;
      default:           rdata_nxt = RTK_RST_REG;
    endcase
  end

  // Read data is captured on the read strobe and held until the next read.
  always_ff @(posedge CLK) begin
    if (sys_rst) begin
      rdata_r <= RTK_RST_REG;
    end else if (SFR_RD) begin
      rdata_r <= rdata_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Status outputs
  // ---------------------------------------------------------------------------

  // Pending interrupt follows the sticky flags; deep sleep waits for a cleared midnight.
  always_ff @(posedge CLK) begin
    if (sys_rst) begin
      irq_r      <= 1'b0;
      sleep_ok_r <= 1'b0;
    end else begin
      irq_r      <= midnight_r || alarm_r;
      sleep_ok_r <= !midnight_r;
    end
  end

  assign SFR_RDATA     = rdata_r;
  assign RTC_IRQ       = irq_r;
  assign DEEP_SLEEP_OK = sleep_ok_r;

endmodule

//--- verilog/rtk_pkg.sv
// Package with register offsets, field positions, reset values and timing constants for the RTC.
package rtk_pkg;

  // ---------------------------------------------------------------------------
  // Register offsets on the special function register bus
  // ---------------------------------------------------------------------------
  localparam logic [7:0] RTK_ADDR_CONFIG   = 8'hA1;
  localparam logic [7:0] RTK_ADDR_FRACTION = 8'hA2;
  localparam logic [7:0] RTK_ADDR_SECOND   = 8'hA3;
  localparam logic [7:0] RTK_ADDR_MINUTE   = 8'hA4;
  localparam logic [7:0] RTK_ADDR_HOUR     = 8'hA5;
  localparam logic [7:0] RTK_ADDR_INTERVAL = 8'hA6;
  localparam logic [7:0] RTK_ADDR_KEY      = 8'hC1;
  localparam logic [7:0] RTK_ADDR_NOMCOMP  = 8'hF6;
  localparam logic [7:0] RTK_ADDR_TEMPCOMP = 8'hF7;
  localparam logic [7:0] RTK_ADDR_INTPIN   = 8'hFF;

  // ---------------------------------------------------------------------------
  // Configuration register fields
  // ---------------------------------------------------------------------------
  localparam int RTK_BIT_MIDNIGHT = 7;
  localparam int RTK_BIT_HOURFMT  = 6;
  localparam int RTK_BIT_TBASE_HI = 5;
  localparam int RTK_BIT_TBASE_LO = 4;
  localparam int RTK_BIT_ONESHOT  = 3;
  localparam int RTK_BIT_ALARM    = 2;
  localparam int RTK_BIT_ITON     = 1;
  localparam int RTK_BIT_RESV     = 0;

  // Interval time base selections.
  localparam logic [1:0] RTK_TB_FRACTION = 2'h0;
  localparam logic [1:0] RTK_TB_SECOND   = 2'h1;
  localparam logic [1:0] RTK_TB_MINUTE   = 2'h2;
  localparam logic [1:0] RTK_TB_HOUR     = 2'h3;

  // ---------------------------------------------------------------------------
  // Reset values and key
  // ---------------------------------------------------------------------------
  localparam logic [7:0] RTK_RST_REG    = 8'h00;
  localparam logic       RTK_RST_RESV   = 1'b1;
  localparam logic [7:0] RTK_UNLOCK_KEY = 8'hEA;

  // ---------------------------------------------------------------------------
  // Counter limits
  // ---------------------------------------------------------------------------
  localparam logic [7:0] RTK_FRACTION_MAX = 8'h7F;
  localparam logic [7:0] RTK_SEC_MAX      = 8'h3B;
  localparam logic [7:0] RTK_MIN_MAX      = 8'h3B;
  localparam logic [7:0] RTK_HOUR24_MAX   = 8'h17;
  localparam logic [7:0] RTK_HOUR256_MAX  = 8'hFF;

  // ---------------------------------------------------------------------------
  // Crystal timing
  // ---------------------------------------------------------------------------
  localparam int          RTK_XTAL_HZ       = 32768;
  localparam int          RTK_FRACTION_HZ   = 128;
  localparam logic [9:0]  RTK_XTAL_PER_TICK = 10'(RTK_XTAL_HZ / RTK_FRACTION_HZ);

endpackage

//--- verilog/rtk_ival_if.sv
// Interface carrying the interval timer controls and its alarm event.
`timescale 1ns/1ps
interface rtk_ival_if;
  logic       tick;
  logic       enable;
  logic       oneshot;
  logic [7:0] limit;
  logic       hit;

  modport ctl (output tick, output enable, output oneshot, output limit, input hit);
  modport tmr (input tick, input enable, input oneshot, input limit, output hit);
endinterface

//--- verilog/rtk_ival.sv
// Eight-bit interval timer that raises a one-cycle hit when its count reaches the limit.
`timescale 1ns/1ps
module rtk_ival
  import rtk_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control and event
  rtk_ival_if.tmr  bus
);

  logic [7:0] count_r;
  logic [7:0] count_nxt;
  logic       done_r;
  logic       hit_r;

  // ---------------------------------------------------------------------------
  // Count
  // ---------------------------------------------------------------------------

  // Next count value after one tick.
  assign count_nxt = count_r + 8'h01;

  // Counter cleared while disabled, advanced on ticks, restarted on a periodic hit.
  always_ff @(posedge clk) begin
    if (rst || !bus.enable) begin
      count_r <= RTK_RST_REG;
    end else if (bus.tick && !done_r) begin
      if (count_nxt == bus.limit && !bus.oneshot) begin
        count_r <= RTK_RST_REG;
      end else begin
        count_r <= count_nxt;
      end
    end
  end

  // One-shot mode stops after the first elapsed interval until re-enabled.
  always_ff @(posedge clk) begin
    if (rst || !bus.enable) begin
      done_r <= 1'b0;
    end else if (bus.tick && !done_r && count_nxt == bus.limit && bus.oneshot) begin
      done_r <= 1'b1;
    end
  end

  // Hit pulse when the count equals the programmed interval.
  always_ff @(posedge clk) begin
    if (rst || !bus.enable) begin
      hit_r <= 1'b0;
    end else begin
      hit_r <= bus.tick && !done_r && (count_nxt == bus.limit);
    end
  end

  assign bus.hit = hit_r;

endmodule

//--- verification/rtk_xtal_model.sv
// Crystal source model for the timekeeper oscillator input.
`timescale 1ns/1ps
module rtk_xtal_model #(
  parameter int HALF_NS = 40
) (
  // Crystal output
  output logic xtal_clk
);
  // Free-running crystal; a short period keeps runs brief, the offset keeps its edges off the CLK edges.
  initial begin
    xtal_clk = 1'b0;
    #3;
    forever #(HALF_NS) xtal_clk = ~xtal_clk;
  end
endmodule

//--- verification/rtk_timekeeper_monitor.sv
// Concurrent checks on the timekeeper register bus and status outputs.
`timescale 1ns/1ps
module rtk_monitor
  import rtk_pkg::*;
(
  // Clock and resets
  input wire logic       CLK,
  input wire logic       RST,
  input wire logic       POR,
  // Register bus
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic       SFR_WR,
  input wire logic       SFR_RD,
  input wire logic [7:0] SFR_RDATA,
  // Status
  input wire logic       RTC_IRQ,
  input wire logic       DEEP_SLEEP_OK
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST || POR);

  AST_IRQ_AFTER_RST: assert property ($fell(RST) |-> !RTC_IRQ)
    else $error("interrupt pending right after reset");
  AST_RDATA_HOLD: assert property (!SFR_RD |=> $stable(SFR_RDATA))
    else $error("read data changed without a read");
  AST_UNMAPPED: assert property (SFR_RD && SFR_ADDR == 8'h00 |=> SFR_RDATA == 8'h00)
    else $error("unmapped read not zero");
  AST_IVAL_RW: assert property (SFR_WR && SFR_ADDR == RTK_ADDR_INTERVAL ##2
    SFR_RD && SFR_ADDR == RTK_ADDR_INTERVAL |=> SFR_RDATA == $past(SFR_WDATA, 3))
    else $error("interval value readback wrong");
  AST_KEY_OPEN: assert property (SFR_WR && SFR_ADDR == RTK_ADDR_KEY && SFR_WDATA == RTK_UNLOCK_KEY ##2
    SFR_WR && SFR_ADDR == RTK_ADDR_SECOND ##2 SFR_RD && SFR_ADDR == RTK_ADDR_SECOND
    |=> SFR_RDATA == $past(SFR_WDATA, 3))
    else $error("unlocked counter write lost");
  AST_DSO_IRQ: assert property ($fell(DEEP_SLEEP_OK) |-> ##[0:2] RTC_IRQ)
    else $error("midnight without interrupt");
  AST_MID_CLEAR: assert property (SFR_WR && SFR_ADDR == RTK_ADDR_CONFIG && !SFR_WDATA[7] && !DEEP_SLEEP_OK
    |-> ##[1:2] DEEP_SLEEP_OK)
    else $error("midnight flag not cleared by write");
  AST_IRQ_FALL: assert property ($fell(RTC_IRQ) |-> $past(SFR_WR, 2) && $past(SFR_ADDR, 2) == RTK_ADDR_CONFIG)
    else $error("interrupt dropped without a clearing write");
endmodule

bind rtk_timekeeper rtk_monitor u_mon (.CLK(CLK), .RST(RST), .POR(POR), .SFR_ADDR(SFR_ADDR),
  .SFR_WDATA(SFR_WDATA), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_RDATA(SFR_RDATA),
  .RTC_IRQ(RTC_IRQ), .DEEP_SLEEP_OK(DEEP_SLEEP_OK));

//--- verification/rtk_timekeeper_bench.sv
// Self-checking bench for the timekeeper.
`timescale 1ns/1ps
module rtk_timekeeper_bench
  import rtk_pkg::*;
;
`define RTK_CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
  logic       clk, rst, por, wr_s, rd_s;
  logic [7:0] addr, wdata;
  wire  [7:0] rdata;
  wire        xtal, irq, dso;
  int         bad_count, compares, cyc;
  logic [7:0] v;
  int         n;

  rtk_xtal_model u_xtal (.xtal_clk(xtal));
  rtk_timekeeper DUT (.CLK(clk), .RST(rst), .POR(por), .XTAL_CLK(xtal), .SFR_ADDR(addr), .SFR_WDATA(wdata),
    .SFR_WR(wr_s), .SFR_RD(rd_s), .SFR_RDATA(rdata), .RTC_IRQ(irq), .DEEP_SLEEP_OK(dso));

  // ---------------------------------------------------------------------------
  // Bus tasks
  // ---------------------------------------------------------------------------
  // Write one byte, then leave one idle cycle.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr_s = 1'b1;
    @(negedge clk);
    wr_s = 1'b0;
    @(negedge clk);
  endtask
  // Read one byte; data is registered at the read edge.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    addr = a;
    rd_s = 1'b1;
    @(negedge clk);
    rd_s = 1'b0;
    d = rdata;
    @(negedge clk);
  endtask
  // Wait for the interrupt under a bound, counting cycles.
  task automatic wait_irq(input int lim, output int c);
    c = 0;
    while (irq !== 1'b1 && c < lim) begin
      @(negedge clk);
      c++;
    end
  endtask
  // Print counts and verdict, then end the run.
  task automatic stop_test;
    $display("compares %0d bad %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  // Reset values, unmapped place and trim setup.
  task automatic t_reset;
    rd(RTK_ADDR_CONFIG, v);
    `RTK_CHK("config", 8'h01, v)
    rd(8'h00, v);
    `RTK_CHK("unmapped", 8'h00, v)
    `RTK_CHK("dso", 1'b1, dso)
    wr(RTK_ADDR_INTERVAL, 8'h55);
    rd(RTK_ADDR_INTERVAL, v);
    `RTK_CHK("interval", 8'h55, v)
    wr(RTK_ADDR_NOMCOMP, 8'h7F);
    wr(RTK_ADDR_TEMPCOMP, 8'h7F);
    rd(RTK_ADDR_TEMPCOMP, v);
    `RTK_CHK("tempcomp", 8'h7F, v)
    $display("done reset");
  endtask
  // Key protection of the counters and the pin configuration.
  task automatic t_lock;
    wr(RTK_ADDR_SECOND, 8'h10);
    wr(RTK_ADDR_INTPIN, 8'h80);
    rd(RTK_ADDR_SECOND, v);
    `RTK_CHK("locked", 8'h00, v)
    rd(RTK_ADDR_INTPIN, v);
    `RTK_CHK("pin_locked", 8'h00, v)
    wr(RTK_ADDR_KEY, RTK_UNLOCK_KEY);
    wr(RTK_ADDR_SECOND, 8'h10);
    rd(RTK_ADDR_SECOND, v);
    `RTK_CHK("open", 8'h10, v)
    wr(RTK_ADDR_INTPIN, 8'h80);
    rd(RTK_ADDR_INTPIN, v);
    `RTK_CHK("pin_open", 8'h80, v)
    wr(RTK_ADDR_KEY, 8'h00);
    wr(RTK_ADDR_SECOND, 8'h22);
    rd(RTK_ADDR_SECOND, v);
    `RTK_CHK("relocked", 8'h10, v)
    $display("done lock");
  endtask
  // Midnight rollover in both hour formats.
  task automatic t_midnight;
    logic fm;
    for (int f = 0; f < 2; f++) begin
      fm = f[0];
      wr(RTK_ADDR_KEY, RTK_UNLOCK_KEY);
      wr(RTK_ADDR_CONFIG, {1'b0, fm, 6'h01});
      wr(RTK_ADDR_HOUR, fm ? RTK_HOUR24_MAX : RTK_HOUR256_MAX);
      wr(RTK_ADDR_MINUTE, RTK_MIN_MAX);
      wr(RTK_ADDR_SECOND, RTK_SEC_MAX);
      wr(RTK_ADDR_FRACTION, RTK_FRACTION_MAX);
      wr(RTK_ADDR_KEY, 8'h00);
      wait_irq(5000, n);
      rd(RTK_ADDR_CONFIG, v);
      `RTK_CHK("midnight", {1'b1, fm, 6'h01}, v)
      rd(RTK_ADDR_HOUR, v);
      `RTK_CHK("hour", 8'h00, v)
      rd(RTK_ADDR_MINUTE, v);
      `RTK_CHK("minute", 8'h00, v)
      rd(RTK_ADDR_SECOND, v);
      `RTK_CHK("second", 8'h00, v)
      `RTK_CHK("dso_low", 1'b0, dso)
      wr(RTK_ADDR_CONFIG, {1'b0, fm, 6'h01});
      `RTK_CHK("dso_back", 1'b1, dso)
      `RTK_CHK("irq_clr", 1'b0, irq)
    end
    $display("done midnight");
  endtask
  // System reset keeps counters and hour format and clears the interval limit.
  task automatic t_sysreset;
    wr(RTK_ADDR_KEY, RTK_UNLOCK_KEY);
    wr(RTK_ADDR_HOUR, 8'h05);
    wr(RTK_ADDR_INTERVAL, 8'h09);
    wr(RTK_ADDR_CONFIG, 8'h43);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    rd(RTK_ADDR_CONFIG, v);
    `RTK_CHK("fmt_kept", 8'h41, v)
    rd(RTK_ADDR_HOUR, v);
    `RTK_CHK("hour_kept", 8'h05, v)
    rd(RTK_ADDR_INTERVAL, v);
    `RTK_CHK("ival_clr", 8'h00, v)
    $display("done sysreset");
  endtask
  // Periodic, one-shot and disabled interval alarm on the fraction base.
  task automatic t_interval;
    wr(RTK_ADDR_INTERVAL, 8'h03);
    for (int k = 0; k < 2; k++) begin
      wr(RTK_ADDR_CONFIG, 8'h03);
      wait_irq(300, n);
      `RTK_CHK("ival_time", 1'b1, (n >= 26 && n <= 56))
      rd(RTK_ADDR_CONFIG, v);
      `RTK_CHK("alarm", 8'h07, v)
    end
    wr(RTK_ADDR_CONFIG, 8'h01);
    wr(RTK_ADDR_CONFIG, 8'h0B);
    wait_irq(300, n);
    `RTK_CHK("oneshot", 1'b1, irq)
    // Clear the alarm first, so that the write of a one can be seen to have no effect.
    wr(RTK_ADDR_CONFIG, 8'h0B);
    wr(RTK_ADDR_CONFIG, 8'h0F);
    rd(RTK_ADDR_CONFIG, v);
    `RTK_CHK("no_set", 8'h0B, v)
    repeat (200) @(negedge clk);
    `RTK_CHK("once", 1'b0, irq)
    wr(RTK_ADDR_CONFIG, 8'h01);
    repeat (200) @(negedge clk);
    `RTK_CHK("off", 1'b0, irq)
    $display("done interval");
  endtask

  // ---------------------------------------------------------------------------
  // Clock, timeout and main sequence
  // ---------------------------------------------------------------------------
  // 100 MHz system clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Cut a hang short.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      bad_count++;
      stop_test();
    end
  end
  // Reset, then run every scenario.
  initial begin
    {rst, por, wr_s, rd_s, addr, wdata} = {2'b11, 2'b00, 16'h0000};
    bad_count = 0;
    compares = 0;
    cyc = 0;
    repeat (3) @(negedge clk);
    {rst, por} = 2'b00;
    t_reset();
    t_lock();
    t_midnight();
    t_sysreset();
    t_interval();
    stop_test();
  end
endmodule
